// ---- inc/counter_array_pkg.sv ----
// Package: register map, field layout and timebase codes for the counter array core
package counter_array_pkg;

   // Register byte offsets on the APB slave
   localparam logic [7:0] OFS_COUNT_LOW  = 8'h00;
   localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
   localparam logic [7:0] OFS_MODE       = 8'h08;
   localparam logic [7:0] OFS_STATUS     = 8'h0C;
   localparam logic [7:0] OFS_MASK       = 8'h10;
   localparam logic [7:0] OFS_CONTROL    = 8'h14;

   // Mode register field positions
   localparam int MODE_IRQ_EN_BIT   = 0;
   localparam int MODE_TB_LSB       = 1;
   localparam int MODE_TB_MSB       = 3;
   localparam int MODE_WDOG_BIT     = 6;
   localparam int MODE_IDLE_BIT     = 7;

   // Status and mask bit positions (same layout)
   localparam int STAT_OVF_BIT      = 0;
   localparam int STAT_REFUSED_BIT  = 1;
   localparam int STAT_WIDTH        = 2;

   // Control register bit positions
   localparam int CTRL_RUN_BIT      = 0;

   // Reset values
   localparam logic [7:0]            MODE_RESET  = 8'h40;
   localparam logic [STAT_WIDTH-1:0] MASK_RESET  = 2'h3;
   localparam logic [15:0]           COUNT_RESET = 16'h0000;
   localparam logic [15:0]           COUNT_MAX   = 16'hFFFF;

   // Timebase codes of timebase_select
   typedef enum logic [2:0] {
      TB_DIV12   = 3'h0,
      TB_DIV4    = 3'h1,
      TB_TIMER0  = 3'h2,
      TB_EXTPIN  = 3'h3,
      TB_SYSCLK  = 3'h4,
      TB_EXTOSC  = 3'h5
   } timebase_e;

   // Divider terminal counts (count runs 0 .. N-1)
   localparam logic [3:0] DIV12_LAST  = 4'hB;
   localparam logic [3:0] DIV4_LAST   = 4'h3;
   localparam logic [3:0] DIVOSC_LAST = 4'h7;

endpackage : counter_array_pkg

// ---- hdl/edge_sync.sv ----
// Two-flop synchroniser with registered rise and fall pulses for an asynchronous input
`timescale 1ns/1ps
module edge_sync (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic asyncIn,
   output logic      risePulse,
   output logic      fallPulse
);

   logic syncFirst;
   logic syncSecond;
   logic syncPrev;

   // First flop is read only by the second, metastability settles here
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         syncFirst  <= 1'b1;
         syncSecond <= 1'b1;
         syncPrev   <= 1'b1;
      end else begin
         syncFirst  <= asyncIn;
         syncSecond <= syncFirst;
         syncPrev   <= syncSecond;
      end
   end

   // Edge pulses come from flops so the consumer sees a clean one-cycle event
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         risePulse <= 1'b0;
         fallPulse <= 1'b0;
      end else begin
         risePulse <= syncSecond & ~syncPrev;
         fallPulse <= ~syncSecond & syncPrev;
      end
   end

endmodule // edge_sync

// ---- hdl/counter_array.sv ----
// Counter array core: 16-bit counter, selectable timebase, snapshot readout, APB registers
`timescale 1ns/1ps

// Contract
// - Counter is 16 bits, read and written as separate low and high byte registers.
// - Reading the low byte snapshots the high byte; next high read returns it.
// - Byte reads and snapshot capture never disturb counting.
// - Timebase 000 sysclk/12, 001 sysclk/4, 010 timer 0 overflow, 100 sysclk.
// - Timebase 011 counts falling edges of the external count input, max sysclk/4.
// - Timebase 101 counts external oscillator divided by 8, synchronised first.
// - Wrap from FFFF to 0000 sets the overflow flag, except when a refused counter byte write lands in the wrap cycle.
// - Overflow raises an interrupt only while the overflow interrupt enable is set.
// - Flag stays set after service; software clears it explicitly.
// - Idle control clear lets the counter run while the processor idles.
// - Watchdog mode is on after reset and restricts certain register writes.
module counter_array
   import counter_array_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        extCountInput,
   input  wire logic        extOscSource,
   input  wire logic        timer0Overflow,
   input  wire logic        cpuIdle,
   output logic             irq,
   output logic             watchdogMode
);

   // Wrapping modulo counter step, shared by both prescalers and the osc divider
   function automatic logic [3:0] wrapStep(input logic [3:0] cur, input logic [3:0] last);
      wrapStep = (cur == last) ? 4'h0 : 4'(cur + 4'h1);
   endfunction

   // Zero-extend a byte into a bus word
   function automatic logic [31:0] byteWord(input logic [7:0] b);
      byteWord = {24'h000000, b};
   endfunction

   // Registers and state
   logic [15:0]           count;
   logic [7:0]            highSnapshot;
   logic                  snapshotValid;
   logic [7:0]            mode;
   logic [STAT_WIDTH-1:0] status;
   logic [STAT_WIDTH-1:0] mask;
   logic                  runEnable;
   logic [3:0]            div12Count;
   logic [3:0]            div4Count;
   logic [3:0]            oscCount;
   logic                  oscTick;
   logic                  extPinFall;
   logic                  oscRise;

   // Bus decode terms
   logic       accessPhase;
   logic       writeCommit;
   logic       readSample;
   logic       addrHit;
   logic       hitLow;
   logic       hitHigh;
   logic       hitMode;
   logic       hitStatus;
   logic       hitMask;
   logic       hitControl;

   // Counter terms
   logic       div12Tick;
   logic       div4Tick;
   logic       tick;
   logic       counting;
   logic       wrapEvent;
   logic       refusedEvent;
   logic       wdogLocked;
   timebase_e  timebase;

   // External pin, falling edges wanted, at most a quarter of the clock rate
   edge_sync u_pin_sync (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .asyncIn   (extCountInput),
      .risePulse (),
      .fallPulse (extPinFall)
   );

   // External oscillator sampled here; it must run below half the clock rate
   edge_sync u_osc_sync (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .asyncIn   (extOscSource),
      .risePulse (oscRise),
      .fallPulse ()
   );

   // APB phases: one wait state, so every access completes on its second access edge
   assign accessPhase = psel & penable;
   assign writeCommit = accessPhase & pready & pwrite;
   assign readSample  = accessPhase & ~pready & ~pwrite;

   // Address decode
   always_comb begin
      hitLow     = 1'b0;
      hitHigh    = 1'b0;
      hitMode    = 1'b0;
      hitStatus  = 1'b0;
      hitMask    = 1'b0;
      hitControl = 1'b0;
      if (paddr == OFS_COUNT_LOW) begin
         hitLow = 1'b1;
      end else if (paddr == OFS_COUNT_HIGH) begin
         hitHigh = 1'b1;
      end else if (paddr == OFS_MODE) begin
         hitMode = 1'b1;
      end else if (paddr == OFS_STATUS) begin
         hitStatus = 1'b1;
      end else if (paddr == OFS_MASK) begin
         hitMask = 1'b1;
      end else if (paddr == OFS_CONTROL) begin
         hitControl = 1'b1;
      end
   end

   assign addrHit = hitLow | hitHigh | hitMode | hitStatus | hitMask | hitControl;

   // Watchdog mode locks the counter bytes and all mode fields but the watchdog bit
   assign wdogLocked = mode[MODE_WDOG_BIT];
   assign timebase   = timebase_e'(mode[MODE_TB_MSB:MODE_TB_LSB]);

   // Ready pulses high for one cycle after the first access cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
      end else begin
         pready <= accessPhase & ~pready;
      end
   end

   // Error answer for unmapped addresses, valid together with ready
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= accessPhase & ~pready & ~addrHit;
      end
   end

   // Read data, loaded in the cycle before ready so it is stable at completion
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
      end else if (readSample) begin
         if (hitLow) begin
            prdata <= byteWord(count[7:0]);
         end else if (hitHigh) begin
            prdata <= byteWord(snapshotValid ? highSnapshot : count[15:8]);
         end else if (hitMode) begin
            prdata <= byteWord(mode);
         end else if (hitStatus) begin
            prdata <= {{(32-STAT_WIDTH){1'b0}}, status};
         end else if (hitMask) begin
            prdata <= {{(32-STAT_WIDTH){1'b0}}, mask};
         end else if (hitControl) begin
            prdata <= {31'h0, runEnable};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Snapshot of the high byte taken in the same cycle the low byte is sampled.
   // Taking both from one clock edge keeps the pair coherent across a carry.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         highSnapshot  <= 8'h00;
         snapshotValid <= 1'b0;
      end else if (readSample & hitLow) begin
         highSnapshot  <= count[15:8];
         snapshotValid <= 1'b1;
      end else if (readSample & hitHigh) begin
         snapshotValid <= 1'b0;
      end
   end

   // Mode register; watchdog enabled from reset, other fields frozen while it is on
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mode <= MODE_RESET;
      end else if (writeCommit & hitMode) begin
         if (wdogLocked) begin
            mode[MODE_WDOG_BIT] <= pwdata[MODE_WDOG_BIT];
         end else begin
            mode <= pwdata[7:0];
         end
      end
   end

   // Registered copy of watchdog state for the rest of the array
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         watchdogMode <= 1'b1;
      end else begin
         watchdogMode <= mode[MODE_WDOG_BIT];
      end
   end

   // Run control lives outside the locked mode register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         runEnable <= 1'b0;
      end else if (writeCommit & hitControl) begin
         runEnable <= pwdata[CTRL_RUN_BIT];
      end
   end

   // Mask register, same layout as status
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mask <= MASK_RESET;
      end else if (writeCommit & hitMask) begin
         mask <= pwdata[STAT_WIDTH-1:0];
      end
   end

   // Fixed prescalers run freely so a timebase change never sees a stale phase
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         div12Count <= 4'h0;
         div4Count  <= 4'h0;
      end else begin
         div12Count <= wrapStep(div12Count, DIV12_LAST);
         div4Count  <= wrapStep(div4Count, DIV4_LAST);
      end
   end

   assign div12Tick = (div12Count == DIV12_LAST);
   assign div4Tick  = (div4Count == DIV4_LAST);

   // Oscillator divide by eight on synchronised rising edges
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         oscCount <= 4'h0;
         oscTick  <= 1'b0;
      end else begin
         oscTick <= oscRise & (oscCount == DIVOSC_LAST);
         if (oscRise) begin
            oscCount <= wrapStep(oscCount, DIVOSC_LAST);
         end
      end
   end

   // Timebase selection; reserved codes give no ticks at all
   always_comb begin
      case (timebase)
         TB_DIV12:  tick = div12Tick;
         TB_DIV4:   tick = div4Tick;
         TB_TIMER0: tick = timer0Overflow;
         TB_EXTPIN: tick = extPinFall;
         TB_SYSCLK: tick = 1'b1;
         TB_EXTOSC: tick = oscTick;
         default:   tick = 1'b0;
      endcase
   end

   // Idle suspends counting only when idle control asks for it
   assign counting  = runEnable & ~(mode[MODE_IDLE_BIT] & cpuIdle);
   assign wrapEvent = counting & tick & (count == COUNT_MAX) & ~(writeCommit & (hitLow | hitHigh));

   // Counter: an accepted byte write wins over a tick in the same cycle; a refused one lets the tick count; reads never touch it
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count <= COUNT_RESET;
      end else if (writeCommit & hitLow & ~wdogLocked) begin
         count[7:0] <= pwdata[7:0];
      end else if (writeCommit & hitHigh & ~wdogLocked) begin
         count[15:8] <= pwdata[7:0];
      end else if (counting & tick) begin
         count <= 16'(count + 16'h0001);
      end
   end

   // Refused writes are reported so software can see the watchdog lock
   // A mode write counts as refused when any bit other than the watchdog bit is one
   assign refusedEvent = writeCommit & wdogLocked & (hitLow | hitHigh |
                         (hitMode & (pwdata[MODE_IDLE_BIT] |
                                     (pwdata[MODE_WDOG_BIT-1:0] != '0))));

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         status <= '0;
      end else begin
         if (wrapEvent) begin
            status[STAT_OVF_BIT] <= 1'b1;
         end else if (writeCommit & hitStatus & pwdata[STAT_OVF_BIT]) begin
            status[STAT_OVF_BIT] <= 1'b0;
         end
         if (refusedEvent) begin
            status[STAT_REFUSED_BIT] <= 1'b1;
         end else if (writeCommit & hitStatus & pwdata[STAT_REFUSED_BIT]) begin
            status[STAT_REFUSED_BIT] <= 1'b0;
         end
      end
   end

   // Interrupt level; overflow needs both its enable bit and its mask bit
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= (status[STAT_OVF_BIT] & mask[STAT_OVF_BIT] & mode[MODE_IRQ_EN_BIT])
              | (status[STAT_REFUSED_BIT] & mask[STAT_REFUSED_BIT]);
      end
   end

endmodule // counter_array

// ---- tb/counter_array_props.sv ----
// Checker: port-level properties of the counter array core
`timescale 1ns/1ps
module counter_array_props
   import counter_array_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        extCountInput,
   input wire logic        extOscSource,
   input wire logic        timer0Overflow,
   input wire logic        cpuIdle,
   input wire logic        irq,
   input wire logic        watchdogMode
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic wrDone;
   logic wrDoneD;
   logic modeWr;
   logic mapped;
   // Completed writes; irq may only fall in the two cycles after one
   assign wrDone = psel && penable && pready && pwrite;
   assign modeWr = wrDone && (paddr == OFS_MODE);
   assign mapped = paddr inside {OFS_COUNT_LOW, OFS_COUNT_HIGH, OFS_MODE, OFS_STATUS,
                                 OFS_MASK, OFS_CONTROL};
   // Delayed write strobe
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) wrDoneD <= 1'b0;
      else wrDoneD <= wrDone;
   end
   AST_READY_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not one wait state after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_DECODE: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not match address decode");
   AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_BYTE_WIDE: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data wider than a byte");
   AST_PRDATA_HOLD: assert property (!$stable(prdata) |-> pready && !pwrite)
      else $error("prdata changed outside a read");
   AST_WDOG_RESET: assert property ($rose(rstn) |-> watchdogMode)
      else $error("watchdog mode off after reset");
   AST_WDOG_KEEP: assert property (!$past(modeWr) |=> $stable(watchdogMode))
      else $error("watchdog mode changed without a mode write");
   AST_WDOG_WRITE: assert property (modeWr |-> ##2 watchdogMode == $past(pwdata[6], 2))
      else $error("watchdog mode not taken from write data");
   AST_IRQ_STICKY: assert property (irq && !wrDone && !wrDoneD |=> irq)
      else $error("irq dropped without a register write");
   cover property ($rose(irq));
   cover property (pready && pslverr);
   cover property (modeWr && !pwdata[MODE_WDOG_BIT]);
endmodule // counter_array_props

// ---- tb/tb_top.sv ----
// Testbench: APB-driven self-checking bench for the counter array core
`timescale 1ns/1ps
module tb_top
   import counter_array_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        watchdogMode;
   logic        extCountInput = 1'b1;
   logic        extOscSource = 1'b0;
   logic        timer0Overflow = 1'b0;
   logic        cpuIdle = 1'b0;
   logic [33:0] notes[$];
   logic [33:0] note;
   logic [7:0]  rstAddr[7] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h00, 8'h04, 8'h18};
   logic [31:0] rstVal[7] = '{32'h40, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};
   int          miscompares = 0;
   int          numChecks = 0;
   int          seed;

   counter_array counter_array_i (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .extCountInput(extCountInput),
      .extOscSource(extOscSource), .timer0Overflow(timer0Overflow), .cpuIdle(cpuIdle),
      .irq(irq), .watchdogMode(watchdogMode));

   // 40 MHz system clock
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One APB transfer; its expectation is queued before the request goes out
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic chk);
      logic err;
      err = !(a inside {OFS_COUNT_LOW, OFS_COUNT_HIGH, OFS_MODE, OFS_STATUS, OFS_MASK,
                        OFS_CONTROL});
      notes.push_back({chk, err, d});
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : 32'h0;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Let the registered irq settle before looking at it
   task automatic irqIs(input logic e);
      repeat (2) @(negedge sys_clk);
      check(irq, {31'h0, e});
   endtask

   // Run 96 cycles on one timebase while every source toggles, then read low byte first
   task automatic measure(input logic [2:0] code, input logic [15:0] start,
                          input logic [7:0] extra);
      int k;
      logic [15:0] exp;
      k = 1 + $urandom % 2;
      xfer(1'b1, OFS_COUNT_LOW, {24'h0, start[7:0]}, 1'b0);
      xfer(1'b1, OFS_COUNT_HIGH, {24'h0, start[15:8]}, 1'b0);
      xfer(1'b1, OFS_MODE, {24'h0, extra | {4'h0, code, 1'b0}}, 1'b0);
      exp = start + ((extra[MODE_IDLE_BIT] && cpuIdle) ? 16'h0 :
         (code == TB_DIV12) ? 16'h8 : (code == TB_DIV4) ? 16'h18 :
         (code == TB_SYSCLK) ? 16'h60 : 16'(k));
      xfer(1'b1, OFS_CONTROL, 32'h1, 1'b0);
      // Pin edges at sysclk/4, oscillator below sysclk/2, 8k oscillator rises
      for (int i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         extOscSource <= (i < 8 * k);
         timer0Overflow <= (i < k);
         extCountInput <= !(i < k);
         @(posedge sys_clk);
         timer0Overflow <= 1'b0;
         @(posedge sys_clk);
         extOscSource <= 1'b0;
         extCountInput <= 1'b1;
         @(posedge sys_clk);
      end
      repeat (28) @(posedge sys_clk);
      xfer(1'b1, OFS_CONTROL, 32'h0, 1'b0);
      xfer(1'b0, OFS_COUNT_LOW, {24'h0, exp[7:0]}, 1'b1);
      xfer(1'b0, OFS_COUNT_HIGH, {24'h0, exp[15:8]}, 1'b1);
   endtask

   // Scoreboard: every completed transfer retires the oldest note
   always @(posedge sys_clk) begin
      if (psel && penable && pready) begin
         note = notes.pop_front();
         check(pslverr, note[32]);
         if (note[33]) check(prdata, note[31:0]);
      end
   end

   initial begin
      seed = $urandom(37);
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      check(watchdogMode, 32'h1);
      foreach (rstAddr[i]) xfer(1'b0, rstAddr[i], rstVal[i], 1'b1);
      // Counter writes and all mode fields but the watchdog bit are refused while the watchdog mode is on
      xfer(1'b1, OFS_COUNT_LOW, 32'h55, 1'b0);
      xfer(1'b1, 8'h18, 32'hFF, 1'b0);
      xfer(1'b0, OFS_COUNT_LOW, 32'h0, 1'b1);
      xfer(1'b0, OFS_STATUS, 32'h2, 1'b1);
      irqIs(1'b1);
      xfer(1'b1, OFS_MODE, 32'h83, 1'b0);
      xfer(1'b0, OFS_MODE, 32'h0, 1'b1);
      check(watchdogMode, 32'h0);
      xfer(1'b1, OFS_STATUS, 32'h3, 1'b0);
      xfer(1'b0, OFS_STATUS, 32'h0, 1'b1);
      irqIs(1'b0);
      // A high-byte write between the paired reads stays hidden behind the snapshot
      xfer(1'b1, OFS_COUNT_LOW, 32'hF0, 1'b0);
      xfer(1'b1, OFS_COUNT_HIGH, 32'h12, 1'b0);
      xfer(1'b0, OFS_COUNT_LOW, 32'hF0, 1'b1);
      xfer(1'b1, OFS_COUNT_HIGH, 32'h34, 1'b0);
      xfer(1'b0, OFS_COUNT_HIGH, 32'h12, 1'b1);
      xfer(1'b0, OFS_COUNT_HIGH, 32'h34, 1'b1);
      // Reserved codes six and seven are never programmed
      for (int c = 0; c < 6; c++) measure(3'(c), 16'($urandom % 32'hFF00), 8'h00);
      cpuIdle <= 1'b1;
      measure(TB_SYSCLK, 16'h1000, 8'h80);
      measure(TB_SYSCLK, 16'h1000, 8'h00);
      cpuIdle <= 1'b0;
      measure(TB_SYSCLK, 16'h2000, 8'h80);
      // Wrap sets the flag; the request follows enable and mask, the flag stays
      measure(TB_SYSCLK, 16'hFFFE, 8'h00);
      xfer(1'b0, OFS_STATUS, 32'h1, 1'b1);
      irqIs(1'b0);
      xfer(1'b1, OFS_MODE, 32'h09, 1'b0);
      irqIs(1'b1);
      xfer(1'b1, OFS_MASK, 32'h0, 1'b0);
      irqIs(1'b0);
      xfer(1'b1, OFS_MASK, 32'h3, 1'b0);
      irqIs(1'b1);
      xfer(1'b0, OFS_STATUS, 32'h1, 1'b1);
      xfer(1'b1, OFS_STATUS, 32'h1, 1'b0);
      irqIs(1'b0);
      results();
   end

   // Hang guard, well beyond the roughly 1330 cycles the sequence needs
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      results();
   end
endmodule // tb_top

bind counter_array counter_array_props counter_array_props_i (.sys_clk(sys_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .extCountInput(extCountInput),
   .extOscSource(extOscSource), .timer0Overflow(timer0Overflow), .cpuIdle(cpuIdle),
   .irq(irq), .watchdogMode(watchdogMode));
